// >>> inc/fwd_pkg.sv
package fwd_pkg;

    // ----------------------------------------------------------------
    // ports and memory
    // ----------------------------------------------------------------
    localparam int         NUM_PORTS  = 4;
    localparam logic [1:0] IN_PORT    = 2'h0;
    localparam int         BUF_BYTES  = 16;
    localparam int         BUF_COPIES = 3;
    localparam int         MEM_DEPTH  = BUF_BYTES * BUF_COPIES;
    localparam logic [1:0] MBX_BANK   = 2'h0;
    localparam logic [1:0] BANK_W_RST = 2'h0;
    localparam logic [1:0] BANK_R_RST = 2'h1;
    localparam logic [1:0] BANK_N_RST = 2'h2;

    // ----------------------------------------------------------------
    // frame layout, byte positions after the preamble
    // ----------------------------------------------------------------
    localparam logic [15:0] ETHERTYPE = 16'h88a4;
    localparam logic [10:0] POS_TYPE_HI = 11'h00c;
    localparam logic [10:0] POS_TYPE_LO = 11'h00d;
    localparam logic [10:0] POS_LEN_LO  = 11'h00e;
    localparam logic [10:0] POS_LEN_HI  = 11'h00f;
    localparam logic [10:0] POS_ADR_LO  = 11'h010;
    localparam logic [10:0] POS_ADR_HI  = 11'h011;

    // ----------------------------------------------------------------
    // check sequence
    // ----------------------------------------------------------------
    localparam logic [31:0] CRC_INIT    = 32'hffffffff;
    localparam logic [31:0] CRC_POLY    = 32'hedb88320;
    localparam logic [31:0] CRC_RESIDUE = 32'hdebb20e3;

    typedef enum logic {
        MODE_MAILBOX  = 1'b0,
        MODE_BUFFERED = 1'b1
    } guard_mode_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_HEAD = 4'b0010,
        ST_DATA = 4'b0100,
        ST_SKIP = 4'b1000
    } proc_state_t;

endpackage : fwd_pkg

// >>> inc/guard_if.sv
`timescale 1ns/1ns
`default_nettype none
interface guard_if;
    fwd_pkg::guard_mode_t mode;
    logic                 wr_en;
    logic [3:0]           wr_addr;
    logic [7:0]           wr_data;
    logic                 commit;
    logic                 abort;
    logic                 wr_blocked;
    logic                 rd_start;
    logic                 rd_en;
    logic [3:0]           rd_addr;
    logic [7:0]           rd_data;
    logic                 rd_done;
    logic                 rd_new;

    modport guard (input mode, wr_en, wr_addr, wr_data, commit, abort,
                   input rd_start, rd_en, rd_addr, rd_done,
                   output wr_blocked, rd_data, rd_new);
    modport user  (output mode, wr_en, wr_addr, wr_data, commit, abort,
                   output rd_start, rd_en, rd_addr, rd_done,
                   input wr_blocked, rd_data, rd_new);
endinterface : guard_if
`default_nettype wire

// >>> logic/buffer_guard.sv
`timescale 1ns/1ns
`default_nettype none
module buffer_guard (
    input  wire logic sys_clk_i,
    input  wire logic rst_n_i,
    guard_if.guard    gd
);

    // ----------------------------------------------------------------
    // storage: three copies for the triple buffer
    // ----------------------------------------------------------------
    logic [7:0] mem [fwd_pkg::MEM_DEPTH];
    logic       full;
    logic       next_full;
    logic       fresh;
    logic       next_fresh;
    logic [1:0] bank_w;
    logic [1:0] bank_r;
    logic [1:0] bank_n;
    logic [1:0] next_bank_w;
    logic [1:0] next_bank_r;
    logic [1:0] next_bank_n;
    logic [7:0] rd_data;
    logic [7:0] next_rd_data;
    logic       buffered;
    logic [1:0] wr_bank;
    logic [1:0] rd_bank;

    assign buffered      = (gd.mode == fwd_pkg::MODE_BUFFERED);
    assign wr_bank       = buffered ? bank_w : fwd_pkg::MBX_BANK;
    assign rd_bank       = buffered ? bank_r : fwd_pkg::MBX_BANK;
    assign gd.wr_blocked = !buffered && full;
    assign gd.rd_new     = buffered ? fresh : full;
    assign gd.rd_data    = rd_data;

    // ----------------------------------------------------------------
    // handshake and bank rotation
    // ----------------------------------------------------------------
    always_comb begin
        next_full    = full;
        next_fresh   = fresh;
        next_bank_w  = bank_w;
        next_bank_r  = bank_r;
        next_bank_n  = bank_n;
        next_rd_data = rd_data;
        if (gd.rd_en) begin
            // empty mailbox reads zero, host never sees a half-written one
            if (buffered || full) begin
                next_rd_data = mem[{rd_bank, gd.rd_addr}];
            end else begin
                next_rd_data = 8'h00;
            end
        end
        if (buffered) begin
            if (gd.commit && gd.rd_start) begin
                // reader takes the buffer just finished; older one is dropped
                next_bank_r = bank_w;
                next_bank_w = bank_r;
                next_fresh  = 1'b0;
            end else if (gd.commit) begin
                next_bank_n = bank_w;
                next_bank_w = bank_n;
                next_fresh  = 1'b1;
            end else if (gd.rd_start && fresh) begin
                next_bank_r = bank_n;
                next_bank_n = bank_r;
                next_fresh  = 1'b0;
            end
        end else begin
            if (gd.commit && !full) begin
                next_full = 1'b1;
            end else if (gd.rd_done && full) begin
                next_full = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            full    <= 1'b0;
            fresh   <= 1'b0;
            bank_w  <= fwd_pkg::BANK_W_RST;
            bank_r  <= fwd_pkg::BANK_R_RST;
            bank_n  <= fwd_pkg::BANK_N_RST;
            rd_data <= 8'h00;
        end else begin
            full    <= next_full;
            fresh   <= next_fresh;
            bank_w  <= next_bank_w;
            bank_r  <= next_bank_r;
            bank_n  <= next_bank_n;
            rd_data <= next_rd_data;
        end
    end

    // writer never touches the bank the reader holds
    always_ff @(posedge sys_clk_i) begin
        if (gd.wr_en && !gd.wr_blocked) begin
            mem[{wr_bank, gd.wr_addr}] <= gd.wr_data;
        end
    end

endmodule : buffer_guard
`default_nettype wire

// >>> logic/fieldbus_port_forward_syncbuf.sv
`timescale 1ns/1ns
`default_nettype none
module fieldbus_port_forward_syncbuf (
    input  wire logic                   sys_clk_i,
    input  wire logic                   rst_n_i,
    input  wire logic [3:0][7:0]        rx_data_i,
    input  wire logic [3:0]             rx_dv_i,
    input  wire logic [3:0]             port_open_i,
    output logic      [3:0][7:0]        tx_data_o,
    output logic      [3:0]             tx_en_o,
    input  wire fwd_pkg::guard_mode_t   guard_mode_i,
    input  wire logic [15:0]            map_log_start_i,
    input  wire logic                   host_rd_start_i,
    input  wire logic                   host_rd_en_i,
    input  wire logic [3:0]             host_rd_addr_i,
    input  wire logic                   host_rd_done_i,
    output logic      [7:0]             host_rd_data_o,
    output logic                        host_data_new_o,
    output logic                        write_blocked_o,
    output logic                        frame_good_o,
    output logic                        frame_bad_o
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // successor in the ring; closed ports are skipped, port 0 closes it
    function automatic logic [1:0] next_open(input logic [1:0] src,
                                             input logic [3:0] open);
        logic [1:0] cand;
        next_open = fwd_pkg::IN_PORT;
        for (int k = fwd_pkg::NUM_PORTS - 1; k >= 1; k--) begin
            cand = src + k[1:0];
            if (open[cand] || cand == fwd_pkg::IN_PORT) begin
                next_open = cand;
            end
        end
    endfunction : next_open

    function automatic logic [31:0] crc_byte(input logic [31:0] crc,
                                             input logic [7:0]  data);
        logic [31:0] c;
        c = crc;
        for (int i = 0; i < 8; i++) begin
            if (c[0] ^ data[i]) begin
                c = (c >> 1) ^ fwd_pkg::CRC_POLY;
            end else begin
                c = c >> 1;
            end
        end
        crc_byte = c;
    endfunction : crc_byte

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [3:0][7:0] rxd_meta;
    logic [3:0][7:0] rxd;
    logic [3:0]      dv_meta;
    logic [3:0]      dv;
    logic [3:0]      open_meta;
    logic [3:0]      open_s;
    // reset to the idle level of dv, so no false start
    logic            dv0_q;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rxd_meta  <= '0;
            rxd       <= '0;
            dv_meta   <= 4'h0;
            dv        <= 4'h0;
            open_meta <= 4'h0;
            open_s    <= 4'h0;
            dv0_q     <= 1'b0;
        end else begin
            rxd_meta  <= rx_data_i;
            rxd       <= rxd_meta;
            dv_meta   <= rx_dv_i;
            dv        <= dv_meta;
            open_meta <= port_open_i;
            open_s    <= open_meta;
            dv0_q     <= dv[fwd_pkg::IN_PORT];
        end
    end

    // ----------------------------------------------------------------
    // forwarding roundabout
    // ----------------------------------------------------------------
    logic [3:0][7:0] tx_data;
    logic [3:0][7:0] next_tx_data;
    logic [3:0]      tx_en;
    logic [3:0]      next_tx_en;
    logic [1:0]      dst;

    // each open port has one ring successor, so no two sources collide
    always_comb begin
        next_tx_data = '0;
        next_tx_en   = 4'h0;
        dst          = fwd_pkg::IN_PORT;
        for (int s = 0; s < fwd_pkg::NUM_PORTS; s++) begin
            // port 0 always carries the upstream link
            if ((s == 0 || open_s[s]) && dv[s]) begin
                // frames from ports 1-3 bypass the processing unit
                dst                = next_open(s[1:0], open_s);
                next_tx_en[dst]    = 1'b1;
                next_tx_data[dst]  = rxd[s];
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_data <= '0;
            tx_en   <= 4'h0;
        end else begin
            tx_data <= next_tx_data;
            tx_en   <= next_tx_en;
        end
    end

    assign tx_data_o = tx_data;
    assign tx_en_o   = tx_en;

    // ----------------------------------------------------------------
    // processing unit behind port 0
    // ----------------------------------------------------------------
    fwd_pkg::proc_state_t state;
    fwd_pkg::proc_state_t next_state;

    // header position and running check sequence
    logic [10:0] cnt;
    logic [10:0] next_cnt;
    logic [31:0] crc;
    logic [31:0] next_crc;
    logic [10:0] len;
    logic [10:0] next_len;

    // datagram window inside the logical image
    logic [15:0] laddr;
    logic [15:0] next_laddr;
    logic [10:0] didx;
    logic [10:0] next_didx;
    logic        wrote;
    logic        next_wrote;

    // write side toward the guard
    logic        wr_en;
    logic        next_wr_en;
    logic [3:0]  wr_addr;
    logic [3:0]  next_wr_addr;
    logic [7:0]  wr_data;
    logic [7:0]  next_wr_data;

    // outcome, decided only once the frame has ended
    logic        commit;
    logic        next_commit;
    logic        abort;
    logic        next_abort;
    logic        good;
    logic        next_good;
    logic        bad;
    logic        next_bad;

    // combinational helpers
    logic [15:0] phys;
    logic [7:0]  b;
    logic        sof;
    logic        eof;

    assign b   = rxd[fwd_pkg::IN_PORT];
    assign sof = dv[fwd_pkg::IN_PORT] && !dv0_q;
    assign eof = !dv[fwd_pkg::IN_PORT] && dv0_q;

    always_comb begin
        next_state   = state;
        next_cnt     = cnt;
        next_crc     = crc;
        next_len     = len;
        next_laddr   = laddr;
        next_didx    = didx;
        next_wrote   = wrote;
        next_wr_en   = 1'b0;
        next_wr_addr = wr_addr;
        next_wr_data = wr_data;
        next_commit  = 1'b0;
        next_abort   = 1'b0;
        next_good    = 1'b0;
        next_bad     = 1'b0;
        // logical image address to offset inside the guarded buffer
        phys = laddr + {5'h00, didx} - map_log_start_i;
        case (state)
            fwd_pkg::ST_IDLE: begin
                if (sof) begin
                    next_state = fwd_pkg::ST_HEAD;
                    next_cnt   = 11'h001;
                    next_crc   = crc_byte(fwd_pkg::CRC_INIT, b);
                    next_wrote = 1'b0;
                end
            end
            fwd_pkg::ST_HEAD, fwd_pkg::ST_DATA: begin
                if (eof) begin
                    next_state = fwd_pkg::ST_IDLE;
                    // fcs is checked only now; writes so far stay uncommitted
                    if (crc == fwd_pkg::CRC_RESIDUE && state == fwd_pkg::ST_DATA) begin
                        next_commit = wrote;
                        next_good   = 1'b1;
                    end else begin
                        next_abort = 1'b1;
                        next_bad   = (crc != fwd_pkg::CRC_RESIDUE);
                    end
                end else if (dv[fwd_pkg::IN_PORT]) begin
                    next_crc = crc_byte(crc, b);
                    next_cnt = cnt + 11'h001;
                    case (cnt)
                        fwd_pkg::POS_TYPE_HI: begin
                            if (b != fwd_pkg::ETHERTYPE[15:8]) begin
                                next_state = fwd_pkg::ST_SKIP;
                            end
                        end
                        fwd_pkg::POS_TYPE_LO: begin
                            if (b != fwd_pkg::ETHERTYPE[7:0]) begin
                                next_state = fwd_pkg::ST_SKIP;
                            end
                        end
                        fwd_pkg::POS_LEN_LO: next_len[7:0]    = b;
                        fwd_pkg::POS_LEN_HI: next_len[10:8]   = b[2:0];
                        fwd_pkg::POS_ADR_LO: next_laddr[7:0]  = b;
                        fwd_pkg::POS_ADR_HI: begin
                            next_laddr[15:8] = b;
                            next_didx        = 11'h000;
                            next_state       = fwd_pkg::ST_DATA;
                        end
                        default: ;
                    endcase
                    // bytes land in memory while the frame is still arriving
                    if (state == fwd_pkg::ST_DATA && didx < len) begin
                        next_didx = didx + 11'h001;
                        if (phys < 16'(fwd_pkg::BUF_BYTES)) begin
                            next_wr_en   = 1'b1;
                            next_wr_addr = phys[3:0];
                            next_wr_data = b;
                            next_wrote   = 1'b1;
                        end
                    end
                end
            end
            fwd_pkg::ST_SKIP: begin
                // foreign frames are forwarded untouched
                if (eof) begin
                    next_state = fwd_pkg::ST_IDLE;
                    next_abort = 1'b1;
                end
            end
            default: next_state = fwd_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state   <= fwd_pkg::ST_IDLE;
            cnt     <= 11'h000;
            crc     <= fwd_pkg::CRC_INIT;
            len     <= 11'h000;
            laddr   <= 16'h0000;
            didx    <= 11'h000;
            wrote   <= 1'b0;
            wr_en   <= 1'b0;
            wr_addr <= 4'h0;
            wr_data <= 8'h00;
            commit  <= 1'b0;
            abort   <= 1'b0;
            good    <= 1'b0;
            bad     <= 1'b0;
        end else begin
            state   <= next_state;
            cnt     <= next_cnt;
            crc     <= next_crc;
            len     <= next_len;
            laddr   <= next_laddr;
            didx    <= next_didx;
            wrote   <= next_wrote;
            wr_en   <= next_wr_en;
            wr_addr <= next_wr_addr;
            wr_data <= next_wr_data;
            commit  <= next_commit;
            abort   <= next_abort;
            good    <= next_good;
            bad     <= next_bad;
        end
    end

    assign frame_good_o = good;
    assign frame_bad_o  = bad;

    // ----------------------------------------------------------------
    // buffer guard between mapping unit and memory
    // ----------------------------------------------------------------
    guard_if gif ();

    assign gif.mode     = guard_mode_i;
    assign gif.wr_en    = wr_en;
    assign gif.wr_addr  = wr_addr;
    assign gif.wr_data  = wr_data;
    assign gif.commit   = commit;
    assign gif.abort    = abort;

    // host side, same clock domain, so no synchroniser
    assign gif.rd_start = host_rd_start_i;
    assign gif.rd_en    = host_rd_en_i;
    assign gif.rd_addr  = host_rd_addr_i;
    assign gif.rd_done  = host_rd_done_i;

    buffer_guard u_guard (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .gd        (gif)
    );

    assign host_rd_data_o  = gif.rd_data;
    assign host_data_new_o = gif.rd_new;
    assign write_blocked_o = gif.wr_blocked;

endmodule : fieldbus_port_forward_syncbuf
`default_nettype wire

// >>> verification/fwd_checker.sv
`timescale 1ns/1ns
`default_nettype none
module fwd_checker (
    input wire logic                 sys_clk_i,
    input wire logic                 rst_n_i,
    input wire logic [3:0][7:0]      rx_data_i,
    input wire logic [3:0]           rx_dv_i,
    input wire logic [3:0]           port_open_i,
    input wire logic [3:0][7:0]      tx_data_o,
    input wire logic [3:0]           tx_en_o,
    input wire fwd_pkg::guard_mode_t guard_mode_i,
    input wire logic                 host_rd_start_i,
    input wire logic                 host_rd_done_i,
    input wire logic                 host_data_new_o,
    input wire logic                 write_blocked_o,
    input wire logic                 frame_good_o,
    input wire logic                 frame_bad_o
);
    logic [1:0] n0;
    logic [1:0] n1;
    logic       mbx;
    // port 0 always counts as open
    function automatic logic [1:0] succ(input logic [3:0] o, input logic [1:0] s);
        logic [1:0] t;
        for (int i = 1; i < 4; i++) begin
            t = s + 2'(i);
            if (o[t] || t == 2'h0) return t;
        end
        return s;
    endfunction : succ
    assign n0  = succ(port_open_i, 2'h0);
    assign n1  = succ(port_open_i, 2'h1);
    assign mbx = guard_mode_i == fwd_pkg::MODE_MAILBOX;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    a_fwd_port0: assert property (rx_dv_i[0] && port_open_i == $past(port_open_i, 4)
        |-> ##3 tx_en_o[$past(n0, 3)] && tx_data_o[$past(n0, 3)] == $past(rx_data_i[0], 3))
        else $error("port 0 byte misrouted");
    a_fwd_return: assert property (rx_dv_i[1] && port_open_i[1]
        && port_open_i == $past(port_open_i, 4)
        |-> ##3 tx_en_o[$past(n1, 3)] && tx_data_o[$past(n1, 3)] == $past(rx_data_i[1], 3))
        else $error("returned byte misrouted");
    a_pulse_excl: assert property (!(frame_good_o && frame_bad_o))
        else $error("good and bad together");
    a_good_single: assert property (frame_good_o |=> !frame_good_o)
        else $error("good pulse too long");
    a_bad_nocommit: assert property (frame_bad_o && !host_data_new_o
        |-> !host_data_new_o [*3]) else $error("bad frame committed");
    a_mbx_hold: assert property (mbx && write_blocked_o && !host_rd_done_i
        |=> write_blocked_o) else $error("mailbox freed early");
    a_mbx_free: assert property (mbx && write_blocked_o && host_rd_done_i
        |=> !write_blocked_o) else $error("mailbox not freed");
    a_buf_open: assert property (!mbx |-> !write_blocked_o)
        else $error("buffered write blocked");
    a_buf_handover: assert property (!mbx && host_rd_start_i |=> !host_data_new_o)
        else $error("new flag kept after read start");
    a_good_fresh: assert property (frame_good_o |-> ##[0:1] host_data_new_o)
        else $error("good frame not offered");
    a_blk_full: assert property ($rose(write_blocked_o) |-> mbx && $past(frame_good_o))
        else $error("blocked without a good frame");
    c_good: cover property (frame_good_o);
    c_bad: cover property (frame_bad_o);
    c_free: cover property (write_blocked_o && host_rd_done_i);
endmodule : fwd_checker
bind fieldbus_port_forward_syncbuf fwd_checker i_chk (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .rx_data_i(rx_data_i), .rx_dv_i(rx_dv_i),
    .port_open_i(port_open_i), .tx_data_o(tx_data_o), .tx_en_o(tx_en_o),
    .guard_mode_i(guard_mode_i), .host_rd_start_i(host_rd_start_i),
    .host_rd_done_i(host_rd_done_i), .host_data_new_o(host_data_new_o),
    .write_blocked_o(write_blocked_o), .frame_good_o(frame_good_o),
    .frame_bad_o(frame_bad_o));
`default_nettype wire

// >>> verification/fwd_partner.sv
`timescale 1ns/1ns
`default_nettype none
module fwd_partner (
    input  wire logic            clk_i,
    input  wire logic [3:0]      port_open_i,
    input  wire logic [3:0][7:0] tx_data_i,
    input  wire logic [3:0]      tx_en_i,
    output logic      [3:0][7:0] rx_data_o,
    output logic      [3:0]      rx_dv_o
);
    bit busy = 1'b0;
    initial begin
        rx_data_o = '0;
        rx_dv_o = '0;
    end
    // followers echo the ring; idle lines never hold their last byte
    always @(negedge clk_i) begin
        for (int p = 1; p < 4; p++) begin
            rx_dv_o[p] <= port_open_i[p] & tx_en_i[p];
            rx_data_o[p] <= (port_open_i[p] & tx_en_i[p]) ? tx_data_i[p] : ~rx_data_o[p];
        end
        if (!busy) rx_data_o[0] <= ~rx_data_o[0];
    end
    // master on the upstream port, one idle cycle after each frame
    task automatic send(input logic [7:0] b [0:63], input int n);
        busy = 1'b1;
        for (int i = 0; i < n; i++) begin
            @(negedge clk_i);
            rx_dv_o[0] <= 1'b1;
            rx_data_o[0] <= b[i];
        end
        @(negedge clk_i);
        rx_dv_o[0] <= 1'b0;
        busy = 1'b0;
    endtask : send
endmodule : fwd_partner
`default_nettype wire

// >>> verification/fieldbus_port_forward_syncbuf_test.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module fieldbus_port_forward_syncbuf_test;
    logic                 clk, rst_n, rd_start, rd_en, rd_done, data_new, blocked, good, bad;
    logic [3:0]           open, rx_dv, tx_en, rd_addr;
    logic [3:0][7:0]      rx_data, tx_data;
    logic [7:0]           rd_data, fb [0:63], pay [0:15], ea [0:15];
    logic [7:0]           q [$];
    logic [15:0]          map_start;
    fwd_pkg::guard_mode_t mode;
    int                   n_errors, cmp_count, n_good, n_bad, nb;

    fieldbus_port_forward_syncbuf i_dut (
        .sys_clk_i(clk), .rst_n_i(rst_n), .rx_data_i(rx_data), .rx_dv_i(rx_dv),
        .port_open_i(open), .tx_data_o(tx_data), .tx_en_o(tx_en), .guard_mode_i(mode),
        .map_log_start_i(map_start), .host_rd_start_i(rd_start), .host_rd_en_i(rd_en),
        .host_rd_addr_i(rd_addr), .host_rd_done_i(rd_done), .host_rd_data_o(rd_data),
        .host_data_new_o(data_new), .write_blocked_o(blocked), .frame_good_o(good),
        .frame_bad_o(bad));
    fwd_partner i_partner (.clk_i(clk), .port_open_i(open), .tx_data_i(tx_data),
        .tx_en_i(tx_en), .rx_data_o(rx_data), .rx_dv_o(rx_dv));

    always #2 clk = ~clk;
    always @(negedge clk) begin
        if (tx_en[0] === 1'b1) q.push_back(tx_data[0]);
        if (good === 1'b1) n_good++;
        if (bad === 1'b1) n_bad++;
    end

    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize

    task automatic do_reset(input fwd_pkg::guard_mode_t m);
        rst_n = 1'b0;
        mode = m;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
    endtask : do_reset

    // -------------------------------------------------------------
    // frame: addresses, type, length, logical address, data, fcs
    // -------------------------------------------------------------
    task automatic build(input int len, input logic [15:0] typ, input bit corrupt);
        logic [31:0] crc;
        crc = fwd_pkg::CRC_INIT;
        nb = 22 + len;
        for (int i = 0; i < nb - 4; i++) begin
            fb[i] = 8'($urandom);
            if (i == 12) fb[i] = typ[15:8];
            if (i == 13) fb[i] = typ[7:0];
            if (i == 14) fb[i] = 8'(len);
            if (i == 15) fb[i] = 8'h00;
            if (i == 16) fb[i] = map_start[7:0];
            if (i == 17) fb[i] = map_start[15:8];
            if (i >= 18) pay[i - 18] = fb[i];
            crc ^= {24'h000000, fb[i]};
            repeat (8) crc = crc[0] ? (crc >> 1) ^ fwd_pkg::CRC_POLY : crc >> 1;
        end
        for (int i = 0; i < 4; i++) fb[nb - 4 + i] = ~crc[8 * i +: 8];
        if (corrupt) fb[nb - 1] ^= 8'h01;
    endtask : build

    task automatic xfer(input int len, input logic [15:0] typ, input bit corrupt,
                        input int eg, input int eb);
        int g0;
        int b0;
        g0 = n_good;
        b0 = n_bad;
        rd_en = 1'b0;
        q.delete();
        build(len, typ, corrupt);
        i_partner.send(fb, nb);
        for (int t = 0; t < 300 && q.size() < nb; t++) @(negedge clk);
        if (q.size() < nb) begin
            n_errors++;
            summarize();
        end
        repeat (6) @(negedge clk);
        for (int i = 0; i < nb; i++) `CHK(q[i], fb[i])
        `CHK(n_good - g0, eg)
        `CHK(n_bad - b0, eb)
    endtask : xfer

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        rd_en = 1'b1;
        rd_addr = a;
        @(negedge clk);
        `CHK(rd_data, e)
    endtask : rd

    task automatic hs(input bit start);
        if (start) rd_start = 1'b1;
        else rd_done = 1'b1;
        rd_en = 1'b0;
        @(negedge clk);
        rd_start = 1'b0;
        rd_done = 1'b0;
    endtask : hs

    initial begin
        clk = 1'b0;
        {rd_start, rd_en, rd_done} = 3'h0;
        rd_addr = 4'h0;
        open = 4'h2;
        void'($urandom(32'h00012a24));
        map_start = 16'($urandom);
        do_reset(fwd_pkg::MODE_MAILBOX);
        xfer(16, fwd_pkg::ETHERTYPE, 1'b0, 1, 0);
        `CHK(blocked, 1'b1)
        ea = pay;
        xfer(16, fwd_pkg::ETHERTYPE, 1'b0, 1, 0);
        for (int i = 0; i < 16; i++) rd(4'(i), ea[i]);
        hs(1'b0);
        `CHK(blocked, 1'b0)
        $display("test mailbox done");
        xfer(8, fwd_pkg::ETHERTYPE, 1'b1, 0, 1);
        `CHK(data_new, 1'b0)
        rd(4'h0, 8'h00);
        xfer(8, 16'h0800, 1'b0, 0, 0);
        `CHK(data_new, 1'b0)
        $display("test reject done");
        for (int k = 0; k < 8; k++) begin
            open = {3'(k), 1'($urandom)};
            repeat (4) @(negedge clk);
            xfer(2 + k, fwd_pkg::ETHERTYPE, 1'b0, 1, 0);
        end
        $display("test ring done");
        open = 4'h2;
        do_reset(fwd_pkg::MODE_BUFFERED);
        xfer(16, fwd_pkg::ETHERTYPE, 1'b0, 1, 0);
        xfer(16, fwd_pkg::ETHERTYPE, 1'b0, 1, 0);
        ea = pay;
        `CHK(blocked, 1'b0)
        hs(1'b1);
        `CHK(data_new, 1'b0)
        xfer(16, fwd_pkg::ETHERTYPE, 1'b0, 1, 0);
        `CHK(data_new, 1'b1)
        for (int i = 0; i < 16; i++) rd(4'(i), ea[i]);
        hs(1'b1);
        for (int i = 0; i < 16; i++) rd(4'(i), pay[i]);
        $display("test buffered done");
        summarize();
    end
endmodule : fieldbus_port_forward_syncbuf_test
`default_nettype wire
